// [rtl/stat_defines.vh]
// Purpose: Constants shared by the clear-on-read statistics block.
// Assumes: One core clock; measurements arrive as signed 16-bit integers.
// Notes:   Floats carry FRAC_BITS fractional bits of fixed point before conversion.
`ifndef STAT_DEFINES_VH
`define STAT_DEFINES_VH

// ============================================================
// Register map of one statistics object
`define STAT_BASE_ADDR    16'h0100
`define STAT_WORDS        16'h0008
`define FLOAT_WORDS       4'h2

// ============================================================
// Exception answers
`define EXC_ILLEGAL_ADDR  8'h02
`define EXC_DEVICE_FAIL   8'h04

// ============================================================
// Number formats
`define FRAC_BITS         8
`define F32_EXP_OFFSET    8'h77
`define F32_EXP_ALL_ONES  8'hFF
`define DIV_STEPS         7'h40
`define SQRT_STEPS        7'h20

`endif

// [rtl/stat_divsqrt.v]
// Purpose: Shared bit-serial unsigned divider and square-root engine.
// Assumes: go is a one-cycle pulse given only while the engine is idle.
// Notes:   Divide takes 64 cycles, square root 32; done pulses one cycle.
`timescale 1ns/1ns
`include "stat_defines.vh"

module stat_divsqrt (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // Operation request
  input  wire        go,
  input  wire        sqrt_mode,
  input  wire [63:0] num,
  input  wire [31:0] den,
  // Answer
  output reg         done,
  output wire [63:0] result
);

  reg  [63:0] acc_reg;
  reg  [33:0] rem_reg;
  reg  [31:0] root_reg;
  reg  [6:0]  step_reg;
  reg         sqrt_reg;
  reg         busy_reg;
  wire [32:0] div_trial;
  wire [35:0] sq_pair;
  wire [35:0] sq_sub;

  // One restoring step of each kind, from the current remainder.
  assign div_trial = {rem_reg[31:0], acc_reg[63]};
  assign sq_pair   = {rem_reg, acc_reg[63:62]};
  assign sq_sub    = {2'b00, root_reg, 2'b01};
  assign result    = sqrt_reg ? {32'h0000_0000, root_reg} : acc_reg;

  // ============================================================
  // Iteration; one engine serves both operations to save area.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg  <= 64'h0;
      rem_reg  <= 34'h0;
      root_reg <= 32'h0;
      step_reg <= 7'h0;
      sqrt_reg <= 1'b0;
      busy_reg <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (go && !busy_reg) begin
        acc_reg  <= num;
        rem_reg  <= 34'h0;
        root_reg <= 32'h0;
        sqrt_reg <= sqrt_mode;
        step_reg <= sqrt_mode ? `SQRT_STEPS : `DIV_STEPS;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (sqrt_reg) begin
          acc_reg <= {acc_reg[61:0], 2'b00};
          if (sq_pair >= sq_sub) begin
            rem_reg  <= sq_pair[33:0] - sq_sub[33:0];
            root_reg <= {root_reg[30:0], 1'b1};
          end else begin
            rem_reg  <= sq_pair[33:0];
            root_reg <= {root_reg[30:0], 1'b0};
          end
        end else begin
          if (div_trial >= {1'b0, den}) begin
            rem_reg <= {1'b0, div_trial - {1'b0, den}};
            acc_reg <= {acc_reg[62:0], 1'b1};
          end else begin
            rem_reg <= {1'b0, div_trial};
            acc_reg <= {acc_reg[62:0], 1'b0};
          end
        end
        step_reg <= step_reg - 7'h1;
        if (step_reg == 7'h1) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
        end
      end
    end
  end

endmodule

// [rtl/clear_on_read_statistics.v]
// Purpose: Statistics object (min, max, average, deviation) read as eight words, cleared on read.
// Assumes: Measurements are signed 16-bit integers; the frame layer feeds decoded read requests.
// Notes:   Floats are truncated, not rounded; the deviation sum wraps after very long runs.
//
// Summary of operation
// - Object is eight words: minimum, maximum, average, deviation floats in order.
// - A read of any subset of the eight words returns just those words.
// - Any read of the object clears all four statistics when it completes.
// - New measurement strictly lower than stored minimum replaces it.
// - New measurement strictly higher than stored maximum replaces it.
// - Average is sum of measurements since last read over their count.
// - Average reads zero when no measurement happened since last read.
// - Per measurement, recompute mean, then add squared deviation from it.
// - Deviation is square root of squared-deviation sum over measurement count.
// - Deviation reads zero when no measurement happened since last read.
// - A register's 16-bit address is the request start address.
// - Word counts: 1 bool/16-bit, 2 32-bit/float, 4 64-bit, 16 text, 8 statistic.
// - Text holds 32 characters, two per word, bytes swapped in each word.
// - Every float is IEEE single precision over two words.
// - A 32-bit value reads with read-holding-registers, count two.
// - Floats go out high half first, low half second.
// - Never return a not-a-number; answer exception code four instead.
`timescale 1ns/1ns
`include "stat_defines.vh"

module clear_on_read_statistics (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // Measurement stream
  input  wire        meas_valid,
  input  wire [15:0] meas_value,
  output reg         meas_ready,
  // Decoded read request
  input  wire        rd_req,
  input  wire [15:0] rd_addr,
  input  wire [15:0] rd_count,
  output reg         rd_ready,
  // Read answer
  output reg         rd_word_valid,
  output reg  [15:0] rd_word,
  output reg         rd_word_last,
  output reg         exc_valid,
  output reg  [7:0]  exc_code
);

  // ============================================================
  // States, one-hot.
  localparam [6:0] ST_IDLE  = 7'b0000001;
  localparam [6:0] ST_MDIV  = 7'b0000010;
  localparam [6:0] ST_RAVG  = 7'b0000100;
  localparam [6:0] ST_RVAR  = 7'b0001000;
  localparam [6:0] ST_RSQRT = 7'b0010000;
  localparam [6:0] ST_BUILD = 7'b0100000;
  localparam [6:0] ST_SEND  = 7'b1000000;

  reg  [6:0]   state_reg;
  reg  signed [15:0] min_reg;
  reg  signed [15:0] max_reg;
  reg  signed [47:0] sum_reg;
  reg  [31:0]  count_reg;
  reg  [63:0]  ssdm_reg;
  reg  signed [15:0] hold_reg;
  reg  [63:0]  avg_mag_reg;
  reg  [63:0]  std_mag_reg;
  reg  [127:0] floats_reg;
  reg  [2:0]   word_reg;
  reg  [3:0]   left_reg;
  reg          eng_go;
  reg          eng_sqrt;
  reg  [63:0]  eng_num;
  wire         eng_done;
  wire [63:0]  eng_result;
  wire [15:0]  rd_off;
  wire [16:0]  rd_end;
  wire         rd_ok;
  wire         take_rd;
  wire         take_meas;
  wire signed [47:0] sum_next;
  wire [47:0]  sum_abs;
  wire signed [31:0] dev;
  wire [63:0]  dev_sq;
  wire [127:0] floats_next;
  wire         has_nan;

  // Magnitude with FRAC_BITS fraction to single precision, truncating.
  function [31:0] to_f32;
    input        neg;
    input [63:0] mag;
    integer      i;
    integer      p;
    reg   [63:0] sh;
    begin
      p = -1;
      for (i = 0; i < 64; i = i + 1) begin
        if (mag[i]) p = i;
      end
      sh = mag << (63 - p);
      if (p < 0) to_f32 = 32'h0000_0000;
      else to_f32 = {neg, p[7:0] + `F32_EXP_OFFSET, sh[62:40]};
    end
  endfunction

  // Absolute value of a 16-bit sample, scaled to the fixed-point grid.
  function [63:0] scaled_mag;
    input signed [15:0] v;
    reg [15:0] a;
    begin
      a = v[15] ? (16'h0000 - v) : v;
      scaled_mag = {40'h0, a, 8'h00};
    end
  endfunction

  // ============================================================
  // Request decode: the object spans eight words from its start address.
  assign rd_off    = rd_addr - `STAT_BASE_ADDR;
  assign rd_end    = {1'b0, rd_off} + {1'b0, rd_count};
  assign rd_ok     = (rd_count != 16'h0) && (rd_end <= {1'b0, `STAT_WORDS});
  assign take_rd   = rd_ready && rd_req;
  assign take_meas = meas_ready && meas_valid && !rd_req;
  assign sum_next  = sum_reg + {{32{meas_value[15]}}, meas_value};
  assign sum_abs   = sum_next[47] ? (48'h0 - sum_next) : sum_next;

  // Deviation of the held sample from the freshly computed mean, fixed point.
  assign dev    = {{8{hold_reg[15]}}, hold_reg, 8'h00}
                - (sum_reg[47] ? (32'h0 - eng_result[31:0]) : eng_result[31:0]);
  assign dev_sq = dev * dev;

  // Four floats in object order; zero count gives zero average and deviation.
  assign floats_next = {to_f32(min_reg[15], scaled_mag(min_reg)),
                        to_f32(max_reg[15], scaled_mag(max_reg)),
                        to_f32(sum_reg[47], avg_mag_reg),
                        to_f32(1'b0, std_mag_reg)};
  assign has_nan = (floats_next[126:119] == `F32_EXP_ALL_ONES) || (floats_next[94:87] == `F32_EXP_ALL_ONES)
                || (floats_next[62:55] == `F32_EXP_ALL_ONES) || (floats_next[30:23] == `F32_EXP_ALL_ONES);

  // ============================================================
  // Engine operand choice follows the state about to wait on it.
  always @* begin
    eng_go   = 1'b0;
    eng_sqrt = 1'b0;
    eng_num  = 64'h0;
    if (take_meas) begin
      eng_go  = 1'b1;
      eng_num = {8'h00, sum_abs, 8'h00};
    end else if (take_rd && rd_ok && count_reg != 32'h0) begin
      eng_go  = 1'b1;
      eng_num = {8'h00, (sum_reg[47] ? (48'h0 - sum_reg) : sum_reg), 8'h00};
    end else if (state_reg == ST_RAVG && eng_done) begin
      eng_go  = 1'b1;
      eng_num = ssdm_reg;  // The sum already holds twice FRAC_BITS of fraction, so the root lands on FRAC_BITS.
    end else if (state_reg == ST_RVAR && eng_done) begin
      eng_go   = 1'b1;
      eng_sqrt = 1'b1;
      eng_num  = eng_result;
    end
  end

  stat_divsqrt u_engine (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .go        (eng_go),
    .sqrt_mode (eng_sqrt),
    .num       (eng_num),
    .den       (take_meas ? (count_reg + 32'h1) : count_reg),
    .done      (eng_done),
    .result    (eng_result)
  );

  // ============================================================
  // Main sequencer. A read wins over a measurement offered in the same cycle.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= ST_IDLE;
      min_reg       <= 16'h0000;
      max_reg       <= 16'h0000;
      sum_reg       <= 48'h0;
      count_reg     <= 32'h0;
      ssdm_reg      <= 64'h0;
      hold_reg      <= 16'h0000;
      avg_mag_reg   <= 64'h0;
      std_mag_reg   <= 64'h0;
      floats_reg    <= 128'h0;
      word_reg      <= 3'h0;
      left_reg      <= 4'h0;
      meas_ready    <= 1'b1;
      rd_ready      <= 1'b1;
      rd_word_valid <= 1'b0;
      rd_word       <= 16'h0000;
      rd_word_last  <= 1'b0;
      exc_valid     <= 1'b0;
      exc_code      <= 8'h00;
    end else begin
      rd_word_valid <= 1'b0;
      rd_word_last  <= 1'b0;
      exc_valid     <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (take_rd) begin
            if (!rd_ok) begin
              exc_valid <= 1'b1;
              exc_code  <= `EXC_ILLEGAL_ADDR;
            end else begin
              word_reg   <= rd_off[2:0];
              left_reg   <= rd_count[3:0];
              meas_ready <= 1'b0;
              rd_ready   <= 1'b0;
              if (count_reg == 32'h0) begin
                avg_mag_reg <= 64'h0;
                std_mag_reg <= 64'h0;
                state_reg   <= ST_BUILD;
              end else begin
                state_reg <= ST_RAVG;
              end
            end
          end else if (take_meas) begin
            hold_reg   <= meas_value;
            sum_reg    <= sum_next;
            count_reg  <= count_reg + 32'h1;
            meas_ready <= 1'b0;
            rd_ready   <= 1'b0;
            state_reg  <= ST_MDIV;
            if (count_reg == 32'h0) begin
              min_reg <= meas_value;
              max_reg <= meas_value;
            end else begin
              if ($signed(meas_value) < min_reg) min_reg <= meas_value;
              if ($signed(meas_value) > max_reg) max_reg <= meas_value;
            end
          end
        end
        ST_MDIV: begin
          if (eng_done) begin
            ssdm_reg   <= ssdm_reg + dev_sq;
            meas_ready <= 1'b1;
            rd_ready   <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        ST_RAVG: begin
          if (eng_done) begin
            avg_mag_reg <= eng_result;
            state_reg   <= ST_RVAR;
          end
        end
        ST_RVAR: begin
          if (eng_done) state_reg <= ST_RSQRT;
        end
        ST_RSQRT: begin
          if (eng_done) begin
            std_mag_reg <= eng_result;
            state_reg   <= ST_BUILD;
          end
        end
        ST_BUILD: begin
          floats_reg <= floats_next;
          if (has_nan) begin
            exc_valid <= 1'b1;
            exc_code  <= `EXC_DEVICE_FAIL;
            left_reg  <= 4'h0;
          end
          state_reg <= ST_SEND;
        end
        ST_SEND: begin
          // Word index picks float (upper bits) and half; even index is the high half.
          if (left_reg != 4'h0) begin
            rd_word_valid <= 1'b1;
            rd_word       <= floats_reg[127 - {word_reg, 4'h0} -: 16];   // (no byte swap: not text)
            rd_word_last  <= (left_reg == 4'h1);
            word_reg      <= word_reg + 3'h1;
            left_reg      <= left_reg - 4'h1;
          end
          if (left_reg <= 4'h1) begin
            // Clearing only after the last word keeps a multi-word read coherent.
            min_reg    <= 16'h0000;
            max_reg    <= 16'h0000;
            sum_reg    <= 48'h0;
            count_reg  <= 32'h0;
            ssdm_reg   <= 64'h0;
            meas_ready <= 1'b1;
            rd_ready   <= 1'b1;
            state_reg  <= ST_IDLE;
          end
        end
        default: begin
          state_reg  <= ST_IDLE;
          meas_ready <= 1'b1;
          rd_ready   <= 1'b1;
        end
      endcase
    end
  end

endmodule

// [tb/stat_props.sv]
// Purpose: Timing checks on the statistics block ports.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Word counting is kept in small helper registers.
`timescale 1ns/1ns
`include "stat_defines.vh"

module stat_props (
  // Clock and reset
  input wire        core_clk,
  input wire        rst_b,
  // Measurement and read request
  input wire        meas_valid,
  input wire [15:0] meas_value,
  input wire        meas_ready,
  input wire        rd_req,
  input wire [15:0] rd_addr,
  input wire [15:0] rd_count,
  input wire        rd_ready,
  // Read answer
  input wire        rd_word_valid,
  input wire [15:0] rd_word,
  input wire        rd_word_last,
  input wire        exc_valid,
  input wire [7:0]  exc_code
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ============================================================
  // Helper logic
  wire       rd_take = rd_req && rd_ready;
  wire       in_obj  = rd_addr >= `STAT_BASE_ADDR && rd_count != 16'h0;
  wire       good_rd = in_obj && ({1'b0, rd_addr} - {1'b0, `STAT_BASE_ADDR} + {1'b0, rd_count} <= 17'h8);
  reg [15:0] want_reg;
  reg [15:0] got_reg;

  // Count words of the answer so that a short or long burst is caught.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      want_reg <= 16'h0;
      got_reg  <= 16'h0;
    end else begin
      if (rd_take)
        want_reg <= rd_count;
      if (rd_word_valid)
        got_reg <= rd_word_last ? 16'h0 : got_reg + 16'h1;
    end
  end

  // ============================================================
  // Assertions
  a_last_in_burst: assert property (rd_word_last |-> rd_word_valid)
    else $error("last flag without a word");
  a_burst_length: assert property (rd_word_last |-> got_reg + 16'h1 == want_reg)
    else $error("answer word count differs from request");
  a_words_back_to_back: assert property (rd_word_valid && !rd_word_last |=> rd_word_valid)
    else $error("gap inside answer burst");
  a_exc_not_words: assert property (!(exc_valid && rd_word_valid))
    else $error("exception and word together");
  a_bad_range_exc: assert property (rd_take && !good_rd |=> exc_valid && exc_code == 8'h02)
    else $error("bad range not refused");
  a_good_read_busy: assert property (rd_take && good_rd |=> !rd_ready && !exc_valid)
    else $error("read not started");
  a_ready_after_last: assert property (rd_word_last |-> ##[0:1] rd_ready)
    else $error("ready missing after last word");
  a_meas_busy: assert property (meas_valid && meas_ready && !rd_req |=> !meas_ready [*8])
    else $error("measurement not taken");
  a_meas_done: assert property (meas_valid && meas_ready && !rd_req |-> ##[60:70] meas_ready)
    else $error("measurement update too long");
endmodule

bind clear_on_read_statistics stat_props stat_props_i (
  .core_clk(core_clk), .rst_b(rst_b), .meas_valid(meas_valid), .meas_value(meas_value),
  .meas_ready(meas_ready), .rd_req(rd_req), .rd_addr(rd_addr), .rd_count(rd_count),
  .rd_ready(rd_ready), .rd_word_valid(rd_word_valid), .rd_word(rd_word),
  .rd_word_last(rd_word_last), .exc_valid(exc_valid), .exc_code(exc_code)
);

// [tb/modbus_master_model.sv]
// Purpose: Request side of a register master issuing decoded reads.
// Assumes: Requests held until taken on a rising edge with rd_ready high.
// Notes:   Released qualifiers show inverted values, never the old ones.
`timescale 1ns/1ns

module modbus_master_model (
  // Clock
  input wire        core_clk,
  // Request
  output reg        rd_req,
  output reg [15:0] rd_addr,
  output reg [15:0] rd_count,
  input wire        rd_ready,
  // Answer
  input wire        rd_word_valid,
  input wire [15:0] rd_word,
  input wire        rd_word_last,
  input wire        exc_valid,
  input wire [7:0]  exc_code
);
  reg [15:0] words [0:7];
  integer    nwords;
  reg        got_exc;
  reg [7:0]  exc_seen;
  reg        hung;

  initial begin
    rd_req   = 1'b0;
    rd_addr  = 16'h0;
    rd_count = 16'h0;
  end

  // One request start address and count; a whole object goes in one request.
  task automatic read(input [15:0] a, input [15:0] c);
    integer t;
    begin
      nwords  = 0;
      got_exc = 1'b0;
      hung    = 1'b0;
      t       = 0;
      @(posedge core_clk);
      rd_req   <= 1'b1;
      rd_addr  <= a;
      rd_count <= c;
      do begin
        @(posedge core_clk);
        t = t + 1;
      end while (rd_ready !== 1'b1 && t < 400);
      rd_req   <= 1'b0;
      rd_addr  <= ~a;
      rd_count <= ~c;
      t = 0;
      while (t < 400) begin
        @(posedge core_clk);
        t = t + 1;
        if (exc_valid === 1'b1) begin
          got_exc  = 1'b1;
          exc_seen = exc_code;
          t = 1000;
        end else if (rd_word_valid === 1'b1) begin
          if (nwords < 8)
            words[nwords] = rd_word;
          nwords = nwords + 1;
          if (rd_word_last === 1'b1)
            t = 1000;
        end
      end
      hung = (t == 400);
    end
  endtask
endmodule

// [tb/clear_on_read_statistics_bench.sv]
// Purpose: Self-checking bench for the clear-on-read statistics block.
// Assumes: Expected floats worked out by hand from exact sample sets.
// Notes:   Samples chosen so average and deviation are exact in fixed point.
`timescale 1ns/1ns

module clear_on_read_statistics_bench;
  reg         core_clk = 1'b0;
  reg         rst_b    = 1'b0;
  reg         meas_valid = 1'b0;
  reg  [15:0] meas_value = 16'h0;
  wire        meas_ready, rd_req, rd_ready, rd_word_valid, rd_word_last, exc_valid;
  wire [15:0] rd_addr, rd_count, rd_word;
  wire [7:0]  exc_code;
  integer     err_count = 0;
  integer     checks_done = 0;
  integer     i;
  // Min -1, max 7, average 1, deviation 3 for samples -1,-1,-1,7.
  reg  [15:0] exp_full [0:7];

  always #2 core_clk = ~core_clk;

  clear_on_read_statistics clear_on_read_statistics_i (
    .core_clk(core_clk), .rst_b(rst_b), .meas_valid(meas_valid), .meas_value(meas_value),
    .meas_ready(meas_ready), .rd_req(rd_req), .rd_addr(rd_addr), .rd_count(rd_count),
    .rd_ready(rd_ready), .rd_word_valid(rd_word_valid), .rd_word(rd_word),
    .rd_word_last(rd_word_last), .exc_valid(exc_valid), .exc_code(exc_code));
  modbus_master_model modbus_master_model_i (
    .core_clk(core_clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_count(rd_count),
    .rd_ready(rd_ready), .rd_word_valid(rd_word_valid), .rd_word(rd_word),
    .rd_word_last(rd_word_last), .exc_valid(exc_valid), .exc_code(exc_code));

  // ============================================================
  // Shared tasks
  task chk(input [127:0] name, input [15:0] exp, input [15:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task print_verdict;
    begin
      if (err_count == 0 && checks_done > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // Offer one sample, then wait until the update has landed.
  task meas(input [15:0] v);
    integer t;
    begin
      t = 0;
      @(posedge core_clk);
      meas_valid <= 1'b1;
      meas_value <= v;
      do begin
        @(posedge core_clk);
        t = t + 1;
      end while (meas_ready !== 1'b1 && t < 200);
      meas_valid <= 1'b0;
      meas_value <= ~v;
      repeat (2) @(posedge core_clk);
      while (meas_ready !== 1'b1 && t < 400) begin
        @(posedge core_clk);
        t = t + 1;
      end
      chk("meas_ready", 16'h1, {15'h0, meas_ready});
    end
  endtask

  // Read and compare against a zero object or the full table.
  task read_obj(input [15:0] a, input [15:0] c, input use_table);
    begin
      modbus_master_model_i.read(a, c);
      chk("word_count", c, modbus_master_model_i.nwords[15:0]);
      chk("read_hung", 16'h0, {15'h0, modbus_master_model_i.hung});
      chk("read_exc", 16'h0, {15'h0, modbus_master_model_i.got_exc});
      for (i = 0; i < c; i = i + 1)
        chk("word", use_table ? exp_full[a - 16'h0100 + i] : 16'h0, modbus_master_model_i.words[i]);
    end
  endtask

  // ============================================================
  // Scenarios
  // Reset holds both ready flags high and the word-valid and exception pulses low.
  task scen_reset;
    begin
      repeat (12) @(posedge core_clk);
      chk("reset_ready", 16'h1, {15'h0, meas_ready & rd_ready});
      chk("reset_word", 16'h0, {14'h0, rd_word_valid, exc_valid});
      rst_b <= 1'b1;
    end
  endtask

  // Before any sample the object reads as four zero floats.
  task scen_empty_read;
    begin
      read_obj(16'h0100, 16'h8, 1'b0);
    end
  endtask

  // Four samples, one full read, then a second read that must find the object cleared.
  task scen_full_object;
    begin
      for (i = 0; i < 3; i = i + 1)
        meas(16'hFFFF);
      meas(16'h0007);
      read_obj(16'h0100, 16'h8, 1'b1);
      read_obj(16'h0100, 16'h8, 1'b0);
    end
  endtask

  // A two-word read of the maximum alone still clears the whole object.
  task scen_partial_read;
    begin
      meas(16'hFFFD);
      modbus_master_model_i.read(16'h0102, 16'h2);
      chk("max_hi", 16'hC040, modbus_master_model_i.words[0]);
      chk("max_lo", 16'h0000, modbus_master_model_i.words[1]);
      chk("max_exc", 16'h0, {15'h0, modbus_master_model_i.got_exc});
      read_obj(16'h0100, 16'h2, 1'b0);
    end
  endtask

  // A range running past the object and a zero count are both refused with no words.
  task scen_bad_range;
    begin
      modbus_master_model_i.read(16'h0107, 16'h2);
      chk("exc_seen", 16'h1, {15'h0, modbus_master_model_i.got_exc});
      chk("exc_code", 16'h0002, {8'h0, modbus_master_model_i.exc_seen});
      chk("exc_words", 16'h0, modbus_master_model_i.nwords[15:0]);
      modbus_master_model_i.read(16'h0100, 16'h0);
      chk("zero_seen", 16'h1, {15'h0, modbus_master_model_i.got_exc});
      chk("zero_code", 16'h0002, {8'h0, modbus_master_model_i.exc_seen});
      chk("zero_words", 16'h0, modbus_master_model_i.nwords[15:0]);
    end
  endtask

  initial begin
    exp_full[0] = 16'hBF80; exp_full[1] = 16'h0000; exp_full[2] = 16'h40E0; exp_full[3] = 16'h0000;
    exp_full[4] = 16'h3F80; exp_full[5] = 16'h0000; exp_full[6] = 16'h4040; exp_full[7] = 16'h0000;
    scen_reset;
    scen_empty_read;
    scen_full_object;
    scen_partial_read;
    scen_bad_range;
    print_verdict;
  end

  // Watchdog well beyond the under one thousand cycles the run needs.
  initial begin
    #80000;
    err_count = err_count + 1;
    print_verdict;
  end
endmodule
